// ### mxc_map.vh
`ifndef MXC_MAP_VH
`define MXC_MAP_VH

// Register offsets on the APB bus
`define MXC_OFS_CTRL    8'h00
`define MXC_OFS_STATUS  8'h04
`define MXC_OFS_WREG    8'h08
`define MXC_OFS_PC      8'h0C

// Control register fields and reset value
`define MXC_CTRL_RUN    0
`define MXC_CTRL_WDTEN  1
`define MXC_CTRL_RST    2'h1

// Status register field positions
`define MXC_ST_CARRY    0
`define MXC_ST_HALF     1
`define MXC_ST_ZERO     2
`define MXC_ST_WRAP     3
`define MXC_ST_SIGNED   4
`define MXC_ST_GIE      5
`define MXC_ST_EXPIRED  6
`define MXC_ST_SLEEP    7

// Instruction word fields
`define MXC_OP_HI       15
`define MXC_OP_LO       11
`define MXC_SUB_LOAD    8
`define MXC_SUB_IRQX    9

// Opcodes
`define MXC_OP_IDLE     5'h00
`define MXC_OP_ADD      5'h01
`define MXC_OP_ADDI     5'h02
`define MXC_OP_SUM_TO_MEM     5'h03
`define MXC_OP_ADC      5'h04
`define MXC_OP_CARRY_SUM_TO_MEM     5'h05
`define MXC_OP_AND      5'h06
`define MXC_OP_ANDI     5'h07
`define MXC_OP_AND_TO_MEM     5'h08
`define MXC_OP_OR       5'h09
`define MXC_OP_ORI      5'h0A
`define MXC_OP_ORM      5'h0B
`define MXC_OP_ZERO     5'h0C
`define MXC_OP_ZEROB    5'h0D
`define MXC_OP_SYS      5'h0E
`define MXC_OP_CPL      5'h0F
`define MXC_OP_COMPLEMENT_TO_WREG     5'h10
`define MXC_OP_BCD      5'h11
`define MXC_OP_DEC      5'h12
`define MXC_OP_MINUS_ONE_TO_WREG     5'h13
`define MXC_OP_INC      5'h14
`define MXC_OP_PLUS_ONE_TO_WREG     5'h15
`define MXC_OP_ROL      5'h16
`define MXC_OP_ROLA     5'h17
`define MXC_OP_ROLC     5'h18
`define MXC_OP_MOVA     5'h19
`define MXC_OP_MOVI     5'h1A
`define MXC_OP_MOVM     5'h1B
`define MXC_OP_BACK     5'h1C
`define MXC_OP_CALL     5'h1D
`define MXC_OP_GOTO     5'h1E

// Reset values and vectors
`define MXC_RST_PC      11'h000
`define MXC_IRQ_VEC     11'h004

// Timing: last clock count of an instruction cycle, watchdog prescale
`define MXC_CYC_CLKS    2'h3
`define MXC_WDT_PRE     8'hFF

`endif

// ### mxc_alu.v
`timescale 1ns/1ps
`default_nettype none
`include "mxc_map.vh"

module mxc_alu (
    input  wire [4:0] op,
    input  wire [7:0] wreg_in,
    input  wire [7:0] mem_in,
    input  wire [7:0] imm_in,
    input  wire [2:0] bit_sel,
    input  wire       carry_in,
    input  wire       half_in,
    output reg  [7:0] result,
    output reg        carry_out,
    output reg        half_out,
    output reg        wrap_out,
    output reg        sgn_out,
    output reg        upd_arith,
    output reg        upd_zero,
    output reg        upd_carry
);

    reg [7:0] addend;
    reg       cin;
    reg [8:0] sum9;
    reg [8:0] bcd9;
    reg [4:0] sum5;
    reg       lo_fix;
    reg       hi_fix;

    ////////////////////////////////////////////////////////////////////
    // Shared adder, immediate forms pick the literal as second operand
    always @* begin
        addend = (op == `MXC_OP_ADDI) ? imm_in : mem_in;
        cin = (op == `MXC_OP_ADC || op == `MXC_OP_CARRY_SUM_TO_MEM) ? carry_in : 1'b0;
        sum9 = {1'b0, wreg_in} + {1'b0, addend} + {8'h00, cin};
        sum5 = {1'b0, wreg_in[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
        lo_fix = (wreg_in[3:0] > 4'h9) | half_in;
        hi_fix = (wreg_in[7:4] > 4'h9) | carry_in;
    end

    ////////////////////////////////////////////////////////////////////
    // Result and flag selection per opcode
    always @* begin
        result    = 8'h00;
        carry_out = carry_in;
        half_out  = 1'b0;
        wrap_out  = 1'b0;
        sgn_out   = 1'b0;
        upd_arith = 1'b0;
        upd_zero  = 1'b0;
        upd_carry = 1'b0;
        bcd9      = 9'h000;
        case (op)
            `MXC_OP_ADD, `MXC_OP_ADDI, `MXC_OP_SUM_TO_MEM,
            `MXC_OP_ADC, `MXC_OP_CARRY_SUM_TO_MEM: begin
                result    = sum9[7:0];
                carry_out = sum9[8];
                half_out  = sum5[4];
                // Wrap when both operands share a sign the sum lacks
                wrap_out  = (wreg_in[7] == addend[7]) &&
                            (sum9[7] != wreg_in[7]);
                sgn_out   = wrap_out ^ sum9[7];           // True sign
                upd_arith = 1'b1;
            end
            `MXC_OP_AND, `MXC_OP_AND_TO_MEM: begin
                result   = wreg_in & mem_in;
                upd_zero = 1'b1;
            end
            `MXC_OP_ANDI: begin
                result   = wreg_in & imm_in;
                upd_zero = 1'b1;
            end
            `MXC_OP_OR, `MXC_OP_ORM: begin
                result   = wreg_in | mem_in;
                upd_zero = 1'b1;
            end
            `MXC_OP_ORI: begin
                result   = wreg_in | imm_in;
                upd_zero = 1'b1;
            end
            `MXC_OP_ZERO:  result = 8'h00;
            `MXC_OP_ZEROB: result = mem_in & ~(8'h01 << bit_sel);
            `MXC_OP_CPL, `MXC_OP_COMPLEMENT_TO_WREG: begin
                result   = ~mem_in;
                upd_zero = 1'b1;
            end
            `MXC_OP_BCD: begin
                // Adjust is a plain add of 00, 06, 60 or 66 hex
                bcd9 = {1'b0, wreg_in} +
                       {1'b0, (hi_fix ? 4'h6 : 4'h0), (lo_fix ? 4'h6 : 4'h0)};
                result    = bcd9[7:0];
                carry_out = carry_in | hi_fix | bcd9[8];
                upd_carry = 1'b1;
            end
            `MXC_OP_DEC, `MXC_OP_MINUS_ONE_TO_WREG: begin
                result   = mem_in - 8'h01;
                upd_zero = 1'b1;
            end
            `MXC_OP_INC, `MXC_OP_PLUS_ONE_TO_WREG: begin
                result   = mem_in + 8'h01;
                upd_zero = 1'b1;
            end
            `MXC_OP_ROL, `MXC_OP_ROLA:
                result = {mem_in[6:0], mem_in[7]};
            `MXC_OP_ROLC: begin
                result    = {mem_in[6:0], carry_in};
                carry_out = mem_in[7];
                upd_carry = 1'b1;
            end
            `MXC_OP_MOVA: result = mem_in;
            `MXC_OP_MOVI: result = imm_in;
            `MXC_OP_MOVM: result = wreg_in;
            default:      result = 8'h00;
        endcase
    end

endmodule // mxc_alu

`default_nettype wire

// ### mxc_core.v
`timescale 1ns/1ps
`default_nettype none
`include "mxc_map.vh"

module mxc_core (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [10:0] pm_addr,
    input  wire [15:0] pm_data,
    output reg  [7:0]  dm_addr,
    output reg  [7:0]  dm_wdata,
    output reg         dm_we,
    input  wire [7:0]  dm_rdata,
    input  wire        irq_req,
    input  wire        wake_req,
    output reg         sys_clk_en
);

    localparam S_FETCH  = 3'h0;
    localparam S_DECODE = 3'h1;
    localparam S_EXEC   = 3'h2;
    localparam S_WRITE  = 3'h3;
    localparam S_DUMMY  = 3'h4;
    localparam S_HALT   = 3'h5;

    reg [2:0]  state;
    reg [1:0]  cnt;
    reg [15:0] ir;
    reg [10:0] pc;
    reg [7:0]  working_register;
    reg        carry_flag;
    reg        half_carry_flag;
    reg        zero_flag;
    reg        arith_wrap_flag;
    reg        signed_carry_flag;
    reg        global_irq_enable;
    reg        sleep_flag;
    reg        expired_flag;
    reg        dbl_cycle;
    reg        halt_pend;
    reg [10:0] stack_mem [0:7];
    reg [2:0]  sp;
    reg [7:0]  wdt_pre;
    reg [7:0]  watchdog_counter;
    reg [1:0]  ctrl;

    wire [4:0] op;
    wire [7:0] alu_res;
    wire       alu_c;
    wire       alu_ac;
    wire       alu_ov;
    wire       alu_sc;
    wire       upd_arith;
    wire       upd_zero;
    wire       upd_carry;
    wire       in_exec;
    wire       wdt_clr;
    wire [7:0] status_byte;

    assign op      = ir[`MXC_OP_HI:`MXC_OP_LO];
    assign in_exec = (state == S_EXEC);
    // Both clear-watchdog and halt restart the watchdog
    assign wdt_clr = in_exec && (op == `MXC_OP_SYS);

    ////////////////////////////////////////////////////////////////////
    // Destination decode, used by write-back only; flags follow the ALU update strobes
    function to_mem;
        input [4:0] code;
        begin
            case (code)
                `MXC_OP_SUM_TO_MEM, `MXC_OP_CARRY_SUM_TO_MEM, `MXC_OP_AND_TO_MEM, `MXC_OP_ORM,
                `MXC_OP_ZERO, `MXC_OP_ZEROB, `MXC_OP_CPL, `MXC_OP_BCD,
                `MXC_OP_DEC, `MXC_OP_INC, `MXC_OP_ROL, `MXC_OP_ROLC,
                `MXC_OP_MOVM: to_mem = 1'b1;
                default:      to_mem = 1'b0;
            endcase
        end
    endfunction

    function to_wreg;
        input [4:0] code;
        begin
            case (code)
                `MXC_OP_ADD, `MXC_OP_ADDI, `MXC_OP_ADC, `MXC_OP_AND,
                `MXC_OP_ANDI, `MXC_OP_OR, `MXC_OP_ORI, `MXC_OP_COMPLEMENT_TO_WREG,
                `MXC_OP_MINUS_ONE_TO_WREG, `MXC_OP_PLUS_ONE_TO_WREG, `MXC_OP_ROLA, `MXC_OP_MOVA,
                `MXC_OP_MOVI: to_wreg = 1'b1;
                default:      to_wreg = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Arithmetic and logic unit
    mxc_alu u_alu (
        .op        (op),
        .wreg_in   (working_register),
        .mem_in    (dm_rdata),
        .imm_in    (ir[7:0]),
        .bit_sel   (ir[10:8]),
        .carry_in  (carry_flag),
        .half_in   (half_carry_flag),
        .result    (alu_res),
        .carry_out (alu_c),
        .half_out  (alu_ac),
        .wrap_out  (alu_ov),
        .sgn_out   (alu_sc),
        .upd_arith (upd_arith),
        .upd_zero  (upd_zero),
        .upd_carry (upd_carry)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencer: fetch, decode, execute, write; four clocks a cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state             <= S_FETCH;
            cnt               <= 2'h0;
            ir                <= 16'h0000;
            pc                <= `MXC_RST_PC;
            pm_addr           <= 11'h000;
            dm_addr           <= 8'h00;
            dm_wdata          <= 8'h00;
            dm_we             <= 1'b0;
            sys_clk_en        <= 1'b1;
            sp                <= 3'h0;
            working_register  <= 8'h00;
            carry_flag        <= 1'b0;
            half_carry_flag   <= 1'b0;
            zero_flag         <= 1'b0;
            arith_wrap_flag   <= 1'b0;
            signed_carry_flag <= 1'b0;
            global_irq_enable <= 1'b0;
            sleep_flag        <= 1'b0;
            dbl_cycle         <= 1'b0;
            halt_pend         <= 1'b0;
        end else begin
            case (state)
                S_FETCH: begin
                    dbl_cycle <= 1'b0;
                    halt_pend <= 1'b0;
                    if (irq_req && global_irq_enable) begin
                        // Entry is checked first, so a request left
                        // pending across an interrupt return wins
                        stack_mem[sp]     <= pc;
                        sp                <= sp + 3'h1;
                        pc                <= `MXC_IRQ_VEC;
                        global_irq_enable <= 1'b0;
                        cnt               <= 2'h0;
                        state             <= S_DUMMY;
                    end else if (ctrl[`MXC_CTRL_RUN]) begin
                        pm_addr <= pc;
                        state   <= S_DECODE;
                    end
                end
                S_DECODE: begin
                    ir      <= pm_data;
                    dm_addr <= pm_data[7:0];
                    pc      <= pc + 11'h001;
                    state   <= S_EXEC;
                end
                S_EXEC: begin
                    // Memory is written only by memory forms
                    dm_we    <= to_mem(op);
                    dm_wdata <= alu_res;
                    if (to_wreg(op))
                        working_register <= alu_res;
                    if (upd_arith) begin
                        carry_flag        <= alu_c;
                        half_carry_flag   <= alu_ac;
                        arith_wrap_flag   <= alu_ov;
                        signed_carry_flag <= alu_sc;
                    end
                    if (upd_carry)
                        carry_flag <= alu_c;
                    if (upd_arith || upd_zero)
                        zero_flag <= (alu_res == 8'h00);
                    case (op)
                        `MXC_OP_CALL: begin
                            stack_mem[sp] <= pc;
                            sp            <= sp + 3'h1;
                            pc            <= ir[10:0];
                            dbl_cycle     <= 1'b1;
                        end
                        `MXC_OP_GOTO: begin
                            pc        <= ir[10:0];
                            dbl_cycle <= 1'b1;
                        end
                        `MXC_OP_BACK: begin
                            sp <= sp - 3'h1;
                            pc <= stack_mem[sp - 3'h1];
                            if (ir[`MXC_SUB_LOAD])
                                working_register <= ir[7:0];
                            if (ir[`MXC_SUB_IRQX])
                                global_irq_enable <= 1'b1;
                        end
                        `MXC_OP_SYS: begin
                            sleep_flag <= ir[`MXC_SUB_LOAD];
                            halt_pend  <= ir[`MXC_SUB_LOAD];
                        end
                        default: dbl_cycle <= 1'b0;
                    endcase
                    state <= S_WRITE;
                end
                S_WRITE: begin
                    dm_we <= 1'b0;
                    cnt   <= 2'h0;
                    if (halt_pend) begin
                        sys_clk_en <= 1'b0;
                        state      <= S_HALT;
                    end else if (dbl_cycle) begin
                        state <= S_DUMMY;
                    end else begin
                        state <= S_FETCH;
                    end
                end
                S_DUMMY: begin
                    // Idle instruction cycle while the new address loads
                    cnt <= cnt + 2'h1;
                    if (cnt == `MXC_CYC_CLKS)
                        state <= S_FETCH;
                end
                S_HALT: begin
                    // Sequencer registers and memory simply hold while asleep
                    if (wake_req || expired_flag) begin
                        sys_clk_en <= 1'b1;
                        state      <= S_FETCH;
                    end
                end
                default: state <= S_FETCH;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Watchdog: prescaler then counter; expiry sets the sticky flag.
    // Keeps running while halted, since it is what wakes a lost core.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_pre          <= 8'h00;
            watchdog_counter <= 8'h00;
            expired_flag     <= 1'b0;
        end else begin
            if (wdt_clr || !ctrl[`MXC_CTRL_WDTEN]) begin
                wdt_pre          <= 8'h00;
                watchdog_counter <= 8'h00;
            end else if (wdt_pre == `MXC_WDT_PRE) begin
                wdt_pre          <= 8'h00;
                watchdog_counter <= watchdog_counter + 8'h01;
            end else begin
                wdt_pre <= wdt_pre + 8'h01;
            end
            // Expiry in the same clock as a clear still sets the flag
            if (ctrl[`MXC_CTRL_WDTEN] &&
                wdt_pre == `MXC_WDT_PRE && watchdog_counter == 8'hFF)
                expired_flag <= 1'b1;
            else if (wdt_clr)
                expired_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave: zero-wait answer, registered read data
    assign status_byte = {sleep_flag, expired_flag, global_irq_enable,
                          signed_carry_flag, arith_wrap_flag, zero_flag,
                          half_carry_flag, carry_flag};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl    <= `MXC_CTRL_RST;
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // Setup phase prepares the answer for the access phase
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (psel && !penable) begin
                case (paddr)
                    `MXC_OFS_CTRL:   prdata <= {30'h0, ctrl};
                    `MXC_OFS_STATUS: prdata <= {24'h0, status_byte};
                    `MXC_OFS_WREG:   prdata <= {24'h0, working_register};
                    `MXC_OFS_PC:     prdata <= {21'h0, pc};
                    default:         pslverr <= 1'b1;
                endcase
            end
            // Writes land only on the completing access edge
            if (psel && penable && pready && pwrite &&
                paddr == `MXC_OFS_CTRL)
                ctrl <= pwdata[1:0];
        end
    end

endmodule // mxc_core

`default_nettype wire

// ### miec_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module miec_core_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [10:0] pm_addr,
    input wire logic        dm_we,
    input wire logic        wake_req,
    input wire logic        sys_clk_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    // Bus answers come one cycle after setup and last one cycle
    ready_one_shot_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer in the cycle after setup");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    idle_rdata_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside access");
    unmapped_err_a: assert property (psel && !penable && paddr > 8'h0C
        |=> pslverr) else $error("unmapped address not refused");
    ////////////////////////////////////////////////////////////////////////
    // One memory write and one fetch per four-clock instruction cycle
    write_gap_a: assert property (dm_we |=> !dm_we [*3])
        else $error("memory writes closer than one instruction");
    fetch_hold_a: assert property ($changed(pm_addr) |=>
        $stable(pm_addr) [*3]) else $error("fetch address held too short");
    halt_freeze_a: assert property (!sys_clk_en && !wake_req |=>
        $stable(pm_addr) && !dm_we) else $error("activity while halted");
endmodule // miec_core_assertions
`default_nettype wire

// ### miec_mem.sv
`timescale 1ns/1ps
`default_nettype none
module miec_mem (
    input  wire logic        pclk,
    input  wire logic [10:0] pm_addr,
    output wire logic [15:0] pm_data,
    input  wire logic [7:0]  dm_addr,
    input  wire logic [7:0]  dm_wdata,
    input  wire logic        dm_we,
    output wire logic [7:0]  dm_rdata
);
    logic [15:0] rom [0:2047];
    logic [7:0]  ram [0:255];
    // Both memories read combinationally, as the core expects
    assign pm_data  = rom[pm_addr];
    assign dm_rdata = ram[dm_addr];
    // Write lands on the edge where the strobe is seen high
    always @(posedge pclk) begin
        if (dm_we) begin
            ram[dm_addr] <= dm_wdata;
        end
    end
endmodule // miec_mem
`default_nettype wire

// ### tb_mcu_instruction_execute_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "mxc_map.vh"
module tb_mcu_instruction_execute_core;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        dm_we, irq_req, wake_req, sys_clk_en, er;
    logic [7:0]  paddr, dm_addr, dm_wdata, dm_rdata;
    logic [31:0] pwdata, prdata, rd;
    logic [10:0] pm_addr;
    logic [15:0] pm_data;
    int          n_fail = 0;
    int          compares = 0;
    int          i;
    // Call at 9 runs 13..16 then returns to the halt at 10
    localparam logic [15:0] PROG [17] = '{
        {`MXC_OP_MOVI, 11'h001}, {`MXC_OP_SUM_TO_MEM, 11'h010},
        {`MXC_OP_MOVA, 11'h011}, {`MXC_OP_SUM_TO_MEM, 11'h011},
        {`MXC_OP_CARRY_SUM_TO_MEM, 11'h012}, {`MXC_OP_ROLC, 11'h013},
        {`MXC_OP_MINUS_ONE_TO_WREG, 11'h010}, {`MXC_OP_ZEROB, 11'h313},
        {`MXC_OP_CPL, 11'h015},  {`MXC_OP_CALL, 11'h00D},
        {`MXC_OP_SYS, 11'h100},  {`MXC_OP_SYS, 11'h000},
        {`MXC_OP_GOTO, 11'h00C}, {`MXC_OP_MOVI, 11'h038},
        {`MXC_OP_ADDI, 11'h049}, {`MXC_OP_BCD, 11'h014},
        {`MXC_OP_BACK, 11'h13C}};
    mxc_core mxc_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pm_addr(pm_addr), .pm_data(pm_data), .dm_addr(dm_addr),
        .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata),
        .irq_req(irq_req), .wake_req(wake_req), .sys_clk_en(sys_clk_en));
    miec_mem miec_mem_i (.pclk(pclk), .pm_addr(pm_addr), .pm_data(pm_data),
        .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we),
        .dm_rdata(dm_rdata));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready without assuming a latency
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_fail++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task report_and_stop;
        $display("compares=%0d mismatches=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, irq_req, wake_req, presetn} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        for (i = 0; i < 2048; i++) miec_mem_i.rom[i] = (i < 17) ? PROG[i] : 16'h0;
        for (i = 0; i < 256; i++) miec_mem_i.ram[i] = 8'h00;
        miec_mem_i.ram[8'h10] = 8'h0F;
        miec_mem_i.ram[8'h11] = 8'h80;
        miec_mem_i.ram[8'h12] = 8'hF0;
        miec_mem_i.ram[8'h13] = 8'h55;
        miec_mem_i.ram[8'h15] = 8'h3C;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `MXC_OFS_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("bus test done");
        i = 0;
        while (sys_clk_en !== 1'b0 && i < 400) begin
            @(posedge pclk);
            i++;
        end
        if (i >= 400) n_fail++;
        apb(1'b0, `MXC_OFS_STATUS, 32'h0);
        chk(rd, 32'h8A);
        @(posedge pclk) wake_req <= 1'b1;
        @(posedge pclk) wake_req <= 1'b0;
        repeat (40) @(posedge pclk);
        apb(1'b0, `MXC_OFS_STATUS, 32'h0);
        chk(rd, 32'h0A);
        apb(1'b1, `MXC_OFS_WREG, 32'hFF);
        apb(1'b0, `MXC_OFS_WREG, 32'h0);
        chk(rd, 32'h3C);
        chk(32'(pm_addr), 32'hC);
        chk(32'(miec_mem_i.ram[8'h10]), 32'h10);
        chk(32'(miec_mem_i.ram[8'h11]), 32'h00);
        chk(32'(miec_mem_i.ram[8'h12]), 32'h71);
        chk(32'(miec_mem_i.ram[8'h13]), 32'hA3);
        chk(32'(miec_mem_i.ram[8'h14]), 32'h87);
        chk(32'(miec_mem_i.ram[8'h15]), 32'hC3);
        $display("program test done");
        apb(1'b1, `MXC_OFS_CTRL, 32'h0);
        apb(1'b0, `MXC_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        $display("control test done");
        report_and_stop;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        report_and_stop;
    end
endmodule // tb_mcu_instruction_execute_core
bind mxc_core miec_core_assertions miec_core_assertions_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dm_we(dm_we),
    .pm_addr(pm_addr), .wake_req(wake_req), .sys_clk_en(sys_clk_en));
`default_nettype wire
